// ===== hdl/mtc_pkg.sv
// Constants for the multi-function timer configuration block: register map,
// field layout, reset values, mode and clock-source encodings.
// Assumes a 32-bit AHB-Lite register bus and one peripheral clock.
package mtc_pkg;

   // -----------------------------------------------------------------------
   // Channel layout
   // -----------------------------------------------------------------------
   localparam int NUM_CH = 5;
   localparam int GR_PER_CH = 4;
   localparam int CH_PAIR_MASTER = 3;
   localparam int CH_PAIR_SLAVE = 4;
   localparam int NUM_CKS = 2;

   // -----------------------------------------------------------------------
   // Register map (byte addresses, one word per register)
   // -----------------------------------------------------------------------
   localparam logic [7:0] MODE_BASE = 8'h00;
   localparam logic [7:0] IOU_BASE = 8'h20;
   localparam logic [7:0] IOL_BASE = 8'h40;
   localparam logic [7:0] CKS_BASE = 8'h60;
   localparam int REG_STRIDE = 4;

   // -----------------------------------------------------------------------
   // Field layout and reset values
   // -----------------------------------------------------------------------
   localparam logic [7:0] MODE_RST = 8'hC0;
   localparam logic [7:0] MODE_FIXED_ONES = 8'hC0;
   localparam logic [7:0] MODE_WMASK_FULL = 8'h3F;
   localparam logic [7:0] MODE_WMASK_SHORT = 8'h0F;
   localparam logic [7:0] IO_RST = 8'h00;
   localparam logic [2:0] CKS_RST = 3'h0;
   localparam int BIT_BUF_SECOND = 5;
   localparam int BIT_BUF_FIRST = 4;
   localparam int IO_CAPTURE_BIT = 3;
   localparam logic [3:0] IO_NIB_OFF = 4'h0;

   // -----------------------------------------------------------------------
   // Operating mode codes
   // -----------------------------------------------------------------------
   localparam logic [3:0] MD_NORMAL = 4'h0;
   localparam logic [3:0] MD_PWM1 = 4'h2;
   localparam logic [3:0] MD_PWM2 = 4'h3;
   localparam logic [3:0] MD_PHASE1 = 4'h4;
   localparam logic [3:0] MD_PHASE2 = 4'h5;
   localparam logic [3:0] MD_PHASE3 = 4'h6;
   localparam logic [3:0] MD_PHASE4 = 4'h7;
   localparam logic [3:0] MD_RSPWM = 4'h8;
   localparam logic [3:0] MD_CPWM_PEAK = 4'hD;
   localparam logic [3:0] MD_CPWM_VALLEY = 4'hE;
   localparam logic [3:0] MD_CPWM_BOTH = 4'hF;

   // -----------------------------------------------------------------------
   // Counter clock source codes and prescaler ratios
   // -----------------------------------------------------------------------
   localparam logic [2:0] CKS_DIV1 = 3'h0;
   localparam logic [2:0] CKS_DIV4 = 3'h1;
   localparam logic [2:0] CKS_DIV16 = 3'h2;
   localparam logic [2:0] CKS_DIV64 = 3'h3;
   localparam logic [2:0] CKS_DIV256 = 3'h4;
   localparam logic [2:0] CKS_DIV1024 = 3'h5;
   localparam logic [2:0] CKS_EXT_A = 3'h6;
   localparam logic [2:0] CKS_EXT_B = 3'h7;
   localparam int LOG2_DIV4 = 2;
   localparam int LOG2_DIV16 = 4;
   localparam int LOG2_DIV64 = 6;
   localparam int LOG2_DIV256 = 8;
   localparam int LOG2_DIV1024 = 10;

endpackage

// ===== hdl/mtc_top.sv
// Configuration logic of the five-channel multi-function timer: mode,
// I/O control and channel 3/4 counter clock-source registers, with the
// decoded per-channel controls presented as registered outputs.
// Assumes a single AHB-Lite master, word accesses and one clock domain;
// the external clock pins are asynchronous and are synchronised here.
//
// Functional notes
// - Channel 3 clock codes: div1,16,64,256, pins A/B.
// - Channel 4 clock codes match channel 3.
// - Codes 001 and 101 give div4 and div1024.
// - Five 8-bit mode registers, reset C0, manual keeps.
// - Mode bits 7 and 6 read one, ignore writes.
// - Second buffer bit: D buffers B, no events.
// - First buffer bit: C buffers A, no events.
// - Channels 1, 2 buffer bits read zero.
// - Mode codes: normal, PWM1, PWM2, phase counting 1-4.
// - Mode codes: reset-sync PWM, complementary PWM 1-3.
// - PWM2 not on 3,4; phase not on 0,3,4.
// - Sync PWM only channel 3; channel 4 follows.
// - Eight I/O control registers across channels.
// - I/O control resets to 00, manual keeps.
// - Upper register: B high nibble, A low.
// - Lower register: D high nibble, C low.
// - Buffered C or D ignores its I/O setting.
// - Nibble selects compare output or capture input.
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns

module mtc_top
   import mtc_pkg::*;
#(
   parameter int PRESCALE_W = 10
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Power control and external count clocks
   input wire logic standby_entry,
   input wire logic ext_clock_pin_a,
   input wire logic ext_clock_pin_b,
   // Decoded per-channel controls
   output logic [NUM_CH*4-1:0] chan_mode,
   output logic [NUM_CH-1:0] buffer_pair_first,
   output logic [NUM_CH-1:0] buffer_pair_second,
   output logic [NUM_CH*GR_PER_CH*4-1:0] gr_io_cfg,
   output logic [NUM_CH*GR_PER_CH-1:0] gr_capture_en,
   output logic [NUM_CH*GR_PER_CH-1:0] gr_compare_en,
   output logic [NUM_CKS*3-1:0] clock_source_select,
   output logic [NUM_CKS-1:0] count_tick
);

   // The prescaler must be wide enough to reach the largest division ratio.
   // Checked at elaboration, so a bad parameter never reaches a netlist.
   if (PRESCALE_W < LOG2_DIV1024) begin : g_prescale_check
      $error("PRESCALE_W too small for the largest prescaler ratio.");
   end

   // -----------------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------------
   function automatic logic has_cd(input int ch);
      return (ch == 0) || (ch == CH_PAIR_MASTER) || (ch == CH_PAIR_SLAVE);
   endfunction

   // Unsupported or reserved codes collapse to normal so that a bad write
   // can never put a channel's datapath into an undefined mode.
   function automatic logic mode_legal(input int ch, input logic [3:0] md);
      logic ok;
      ok = 1'b0;
      case (md)
         MD_NORMAL, MD_PWM1: begin
            ok = 1'b1;
         end
         MD_PWM2: begin
            ok = (ch != CH_PAIR_MASTER) && (ch != CH_PAIR_SLAVE);
         end
         MD_PHASE1, MD_PHASE2, MD_PHASE3, MD_PHASE4: begin
            ok = !has_cd(ch);
         end
         MD_RSPWM, MD_CPWM_PEAK, MD_CPWM_VALLEY, MD_CPWM_BOTH: begin
            ok = (ch == CH_PAIR_MASTER);
         end
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction

   function automatic logic is_sync_pwm(input logic [3:0] md);
      return (md == MD_RSPWM) || (md == MD_CPWM_PEAK) || (md == MD_CPWM_VALLEY) || (md == MD_CPWM_BOTH);
   endfunction

   // -----------------------------------------------------------------------
   // Bus address phase capture
   // -----------------------------------------------------------------------
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic addr_ok;
   logic rd_take;

   assign addr_ok = hsel && hready && htrans[1];
   assign rd_take = addr_ok && !hwrite;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else if (hready) begin
         wr_pend_q <= addr_ok && hwrite;
         wr_addr_q <= haddr[7:0];
      end
   end

   // The slave never stalls and never errors.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // -----------------------------------------------------------------------
   // Register file
   // -----------------------------------------------------------------------
   logic [7:0] mode_q [NUM_CH];
   logic [7:0] mode_d [NUM_CH];
   logic [7:0] iou_q [NUM_CH];
   logic [7:0] iou_d [NUM_CH];
   logic [7:0] iol_q [NUM_CH];
   logic [7:0] iol_d [NUM_CH];
   logic [2:0] cks_q [NUM_CKS];
   logic [2:0] cks_d [NUM_CKS];

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         mode_d[i] = mode_q[i];
         iou_d[i] = iou_q[i];
         iol_d[i] = iol_q[i];
         if (wr_pend_q && (wr_addr_q == MODE_BASE + 8'(REG_STRIDE * i))) begin
            mode_d[i] = (hwdata[7:0] & (has_cd(i) ? MODE_WMASK_FULL : MODE_WMASK_SHORT))
                        | MODE_FIXED_ONES;
         end
         if (wr_pend_q && (wr_addr_q == IOU_BASE + 8'(REG_STRIDE * i))) begin
            iou_d[i] = hwdata[7:0];
         end
         if (has_cd(i) && wr_pend_q && (wr_addr_q == IOL_BASE + 8'(REG_STRIDE * i))) begin
            iol_d[i] = hwdata[7:0];
         end
         // Standby reinitialises like power-on; no manual reset input exists.
         if (standby_entry) begin
            mode_d[i] = MODE_RST;
            iou_d[i] = IO_RST;
            iol_d[i] = IO_RST;
         end
      end
      for (int k = 0; k < NUM_CKS; k++) begin
         cks_d[k] = cks_q[k];
         if (wr_pend_q && (wr_addr_q == CKS_BASE + 8'(REG_STRIDE * k))) begin
            cks_d[k] = hwdata[2:0];
         end
         if (standby_entry) begin
            cks_d[k] = CKS_RST;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NUM_CH; i++) begin
            mode_q[i] <= MODE_RST;
            iou_q[i] <= IO_RST;
            iol_q[i] <= IO_RST;
         end
         for (int k = 0; k < NUM_CKS; k++) begin
            cks_q[k] <= CKS_RST;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            mode_q[i] <= mode_d[i];
            iou_q[i] <= iou_d[i];
            iol_q[i] <= iol_d[i];
         end
         for (int k = 0; k < NUM_CKS; k++) begin
            cks_q[k] <= cks_d[k];
         end
      end
   end

   // -----------------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------------
   // Reads look at next-state values so that a read right behind a write
   // to the same register returns the freshly written data.
   logic [7:0] rd_val;

   always_comb begin
      rd_val = 8'h00;
      for (int i = 0; i < NUM_CH; i++) begin
         if (haddr[7:0] == MODE_BASE + 8'(REG_STRIDE * i)) begin
            rd_val = mode_d[i];
         end
         if (haddr[7:0] == IOU_BASE + 8'(REG_STRIDE * i)) begin
            rd_val = iou_d[i];
         end
         if (has_cd(i) && (haddr[7:0] == IOL_BASE + 8'(REG_STRIDE * i))) begin
            rd_val = iol_d[i];
         end
      end
      for (int k = 0; k < NUM_CKS; k++) begin
         if (haddr[7:0] == CKS_BASE + 8'(REG_STRIDE * k)) begin
            rd_val = {5'h00, cks_d[k]};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata <= {24'h00_0000, rd_val};
      end
   end

   // -----------------------------------------------------------------------
   // Mode decode and channel 4 slaving
   // -----------------------------------------------------------------------
   logic [3:0] md_eff [NUM_CH];
   logic [NUM_CH-1:0] bfa_eff;
   logic [NUM_CH-1:0] bfb_eff;
   logic [2:0] cks_eff [NUM_CKS];
   logic ch3_sync;

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         md_eff[i] = mode_legal(i, mode_q[i][3:0]) ? mode_q[i][3:0] : MD_NORMAL;
         bfa_eff[i] = has_cd(i) && mode_q[i][BIT_BUF_FIRST];
         bfb_eff[i] = has_cd(i) && mode_q[i][BIT_BUF_SECOND];
      end
      for (int k = 0; k < NUM_CKS; k++) begin
         cks_eff[k] = cks_q[k];
      end
      ch3_sync = is_sync_pwm(md_eff[CH_PAIR_MASTER]);
      if (ch3_sync) begin
         md_eff[CH_PAIR_SLAVE] = md_eff[CH_PAIR_MASTER];
         bfa_eff[CH_PAIR_SLAVE] = bfa_eff[CH_PAIR_MASTER];
         bfb_eff[CH_PAIR_SLAVE] = bfb_eff[CH_PAIR_MASTER];
         cks_eff[1] = cks_eff[0];
      end
   end

   // -----------------------------------------------------------------------
   // I/O control decode
   // -----------------------------------------------------------------------
   logic [3:0] nib [NUM_CH][GR_PER_CH];
   logic [NUM_CH-1:0][GR_PER_CH-1:0] gr_live;

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         nib[i][0] = iou_q[i][3:0];
         nib[i][1] = iou_q[i][7:4];
         nib[i][2] = bfa_eff[i] ? IO_NIB_OFF : iol_q[i][3:0];
         nib[i][3] = bfb_eff[i] ? IO_NIB_OFF : iol_q[i][7:4];
         gr_live[i][0] = 1'b1;
         gr_live[i][1] = 1'b1;
         gr_live[i][2] = has_cd(i) && !bfa_eff[i];
         gr_live[i][3] = has_cd(i) && !bfb_eff[i];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan_mode <= '0;
         buffer_pair_first <= '0;
         buffer_pair_second <= '0;
         gr_io_cfg <= '0;
         gr_capture_en <= '0;
         gr_compare_en <= '0;
         clock_source_select <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            chan_mode[i*4 +: 4] <= md_eff[i];
            buffer_pair_first[i] <= bfa_eff[i];
            buffer_pair_second[i] <= bfb_eff[i];
            for (int g = 0; g < GR_PER_CH; g++) begin
               gr_io_cfg[(i*GR_PER_CH+g)*4 +: 4] <= gr_live[i][g] ? nib[i][g] : IO_NIB_OFF;
               gr_capture_en[i*GR_PER_CH+g] <= gr_live[i][g] && nib[i][g][IO_CAPTURE_BIT];
               gr_compare_en[i*GR_PER_CH+g] <= gr_live[i][g] && !nib[i][g][IO_CAPTURE_BIT];
            end
         end
         for (int k = 0; k < NUM_CKS; k++) begin
            clock_source_select[k*3 +: 3] <= cks_eff[k];
         end
      end
   end

   // -----------------------------------------------------------------------
   // Prescaler and external clock pins
   // -----------------------------------------------------------------------
   logic [PRESCALE_W-1:0] pre_q;
   logic [2:0] pin_a_q;
   logic [2:0] pin_b_q;
   logic edge_a;
   logic edge_b;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + PRESCALE_W'(1);
      end
   end

   // Stage 0 feeds only stage 1; edges are taken from stages 1 and 2.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_a_q <= 3'h0;
         pin_b_q <= 3'h0;
      end else begin
         pin_a_q <= {pin_a_q[1:0], ext_clock_pin_a};
         pin_b_q <= {pin_b_q[1:0], ext_clock_pin_b};
      end
   end

   assign edge_a = pin_a_q[1] && !pin_a_q[2];
   assign edge_b = pin_b_q[1] && !pin_b_q[2];

   function automatic logic src_tick(input logic [2:0] code, input logic [PRESCALE_W-1:0] p,
                                     input logic ea, input logic eb);
      logic t;
      t = 1'b0;
      case (code)
         CKS_DIV1: begin
            t = 1'b1;
         end
         CKS_DIV4: begin
            t = &p[LOG2_DIV4-1:0];
         end
         CKS_DIV16: begin
            t = &p[LOG2_DIV16-1:0];
         end
         CKS_DIV64: begin
            t = &p[LOG2_DIV64-1:0];
         end
         CKS_DIV256: begin
            t = &p[LOG2_DIV256-1:0];
         end
         CKS_DIV1024: begin
            t = &p[LOG2_DIV1024-1:0];
         end
         CKS_EXT_A: begin
            t = ea;
         end
         CKS_EXT_B: begin
            t = eb;
         end
         default: begin
            t = 1'b0;
         end
      endcase
      return t;
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_tick <= '0;
      end else begin
         for (int k = 0; k < NUM_CKS; k++) begin
            count_tick[k] <= src_tick(cks_eff[k], pre_q, edge_a, edge_b);
         end
      end
   end

endmodule

// ===== tb/mtc_checker.sv
// Concurrent checks on the ports of the timer configuration block.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ns
module mtc_checker
   import mtc_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus answer
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // Decoded controls
   input wire logic [NUM_CH*4-1:0] chan_mode,
   input wire logic [NUM_CH-1:0] buffer_pair_first,
   input wire logic [NUM_CH-1:0] buffer_pair_second,
   input wire logic [NUM_CH*GR_PER_CH*4-1:0] gr_io_cfg,
   input wire logic [NUM_CH*GR_PER_CH-1:0] gr_capture_en,
   input wire logic [NUM_CH*GR_PER_CH-1:0] gr_compare_en,
   input wire logic [NUM_CKS*3-1:0] clock_source_select,
   input wire logic [NUM_CKS-1:0] count_tick
);
   // Outputs leave reset one edge late, so relations wait until up_q saturates.
   logic [1:0] up_q;
   logic [4:0] c_act;
   logic [4:0] d_act;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_q <= 2'h0;
      end else if (up_q != 2'h3) begin
         up_q <= up_q + 2'h1;
      end
   end
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         c_act[i] = gr_capture_en[i*4+2] | gr_compare_en[i*4+2] | (gr_io_cfg[(i*4+2)*4 +: 4] != 4'h0);
         d_act[i] = gr_capture_en[i*4+3] | gr_compare_en[i*4+3] | (gr_io_cfg[(i*4+3)*4 +: 4] != 4'h0);
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (up_q == 2'h3 |-> hreadyout && !hresp && hrdata[31:8] == 24'h0)
      else $error("bus answer not okay");
   a_buf_b_quiet: assert property (up_q == 2'h3 |-> (buffer_pair_second & d_act) == 5'h0)
      else $error("buffered D still active");
   a_buf_a_quiet: assert property (up_q == 2'h3 |-> (buffer_pair_first & c_act) == 5'h0)
      else $error("buffered C still active");
   a_short_no_buf: assert property ((buffer_pair_first[2:1] | buffer_pair_second[2:1]) == 2'h0)
      else $error("buffer on short channel");
   a_cap_cmp_excl: assert property (up_q == 2'h3 |-> (gr_capture_en & gr_compare_en) == 20'h0_0000)
      else $error("capture and compare both on");
   a_cap_follows_nib: assert property (up_q == 2'h3 |->
      gr_capture_en[0] == gr_io_cfg[3] && gr_compare_en[0] != gr_io_cfg[3])
      else $error("capture enable not from nibble");
   a_ch4_follows: assert property (
      up_q == 2'h3 && chan_mode[15:12] >= MD_RSPWM |-> chan_mode[19:16] == chan_mode[15:12]
      && buffer_pair_first[4] == buffer_pair_first[3] && buffer_pair_second[4] == buffer_pair_second[3]
      && clock_source_select[5:3] == clock_source_select[2:0])
      else $error("channel 4 not following channel 3");
   a_sync_ch3_only: assert property (chan_mode[19:16] >= MD_RSPWM |-> chan_mode[15:12] == chan_mode[19:16])
      else $error("sync mode outside channel 3");
   a_no_pwm2_phase: assert property (
      chan_mode[15:12] != MD_PWM2 && !(chan_mode[15:12] inside {[MD_PHASE1:MD_PHASE4]})
      && chan_mode[19:16] != MD_PWM2 && !(chan_mode[19:16] inside {[MD_PHASE1:MD_PHASE4]})
      && chan_mode[7:4] < MD_RSPWM && chan_mode[11:8] < MD_RSPWM
      && !(chan_mode[3:0] inside {[MD_PHASE1:MD_PHASE4]}) && chan_mode[3:0] < MD_RSPWM)
      else $error("unavailable mode decoded");
   a_div1_tick: assert property ((clock_source_select[2:0] == CKS_DIV1) [*3] |-> count_tick[0])
      else $error("divide by one tick missing");
   a_div1_tick4: assert property ((clock_source_select[5:3] == CKS_DIV1) [*3] |-> count_tick[1])
      else $error("divide by one tick missing");
endmodule

// ===== tb/test_multi_timer_mode_io_config.sv
// Self-checking bench for the timer configuration block over AHB-Lite.
// Assumes hready is looped back from hreadyout and word accesses only.
`timescale 1ns/1ns
module test_multi_timer_mode_io_config;
   import mtc_pkg::*;
   logic hclk, hresetn, hsel, hwrite, standby_entry, pin_a, pin_b, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0] htrans, tick;
   logic [19:0] chan_mode, cap_en, cmp_en;
   logic [4:0] bf_a, bf_b;
   logic [79:0] io_cfg;
   logic [5:0] cks;
   int mismatches, checks_done;
   int cyc = 0;
   mtc_top mtc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .standby_entry(standby_entry), .ext_clock_pin_a(pin_a),
      .ext_clock_pin_b(pin_b), .chan_mode(chan_mode), .buffer_pair_first(bf_a), .buffer_pair_second(bf_b),
      .gr_io_cfg(io_cfg), .gr_capture_en(cap_en), .gr_compare_en(cmp_en), .clock_source_select(cks),
      .count_tick(tick));
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // Pins toggle with periods of 16 and 32 cycles; cyc also bounds the run at 40000 cycles.
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      pin_a <= cyc[3];
      pin_b <= cyc[4];
      if (cyc == 40000) begin
         mismatches++;
         finish_test();
      end
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input int a, input logic [7:0] d);
      bus(1'b1, 8'(a), {24'h00_0000, d}, rdv);
   endtask
   task automatic rd_chk(input int a, input logic [7:0] e);
      bus(1'b0, 8'(a), 32'h0000_0000, rdv);
      check(rdv, {24'h00_0000, e});
   endtask
   task automatic settle();
      repeat (2) @(negedge hclk);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_reset();
      for (int i = 0; i < 5; i++) begin
         rd_chk(MODE_BASE + 4*i, 8'hC0);
         rd_chk(IOU_BASE + 4*i, 8'h00);
         if (i == 0 || i > 2) rd_chk(IOL_BASE + 4*i, 8'h00);
      end
      rd_chk(CKS_BASE, 8'h00);
      wr(IOL_BASE + 4, 8'hFF);
      rd_chk(IOL_BASE + 4, 8'h00);
      rd_chk(8'h80, 8'h00);
      $display("reset test done");
   endtask
   task automatic test_fixed();
      for (int i = 0; i < 5; i++) wr(MODE_BASE + 4*i, 8'hF2);
      settle();
      check(32'({bf_a, bf_b}), 32'h0000_0339);
      for (int i = 0; i < 5; i++) rd_chk(MODE_BASE + 4*i, (i == 1 || i == 2) ? 8'hC2 : 8'hF2);
      for (int i = 0; i < 5; i++) wr(MODE_BASE + 4*i, 8'h00);
      rd_chk(MODE_BASE, 8'hC0);
      $display("fixed bits test done");
   endtask
   task automatic test_modes();
      logic [3:0] legal[7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
      logic [3:0] sync[4] = '{MD_RSPWM, MD_CPWM_PEAK, MD_CPWM_VALLEY, MD_CPWM_BOTH};
      int bad[6][2] = '{'{4, 8}, '{3, 3}, '{3, 4}, '{0, 5}, '{1, 13}, '{2, 8}};
      foreach (legal[i]) begin
         wr(MODE_BASE + 4, {4'h0, legal[i]});
         settle();
         check(32'(chan_mode[7:4]), 32'(legal[i]));
      end
      wr(CKS_BASE, 8'h03);
      foreach (sync[i]) begin
         wr(MODE_BASE + 12, {4'h3, sync[i]});
         settle();
         check(32'({chan_mode[19:12], bf_a[4], bf_b[4], cks[5:3]}), 32'({sync[i], sync[i], 5'h1B}));
      end
      foreach (bad[i]) begin
         wr(MODE_BASE + 12, 8'h00);
         wr(MODE_BASE + 4*bad[i][0], 8'(bad[i][1]));
         settle();
         check(32'(chan_mode[4*bad[i][0] +: 4]), 32'h0000_0000);
         wr(MODE_BASE + 4*bad[i][0], 8'h00);
      end
      wr(CKS_BASE, 8'h00);
      $display("mode test done");
   endtask
   task automatic test_io();
      wr(IOU_BASE, 8'h98);
      wr(IOL_BASE, 8'hA1);
      wr(IOU_BASE + 4, 8'h7F);
      settle();
      check(32'({io_cfg[15:0], cap_en[3:0], cmp_en[3:0]}), 32'h00A1_98B4);
      check(32'({io_cfg[23:16], cap_en[5:4], cmp_en[5:4]}), 32'h0000_07F6);
      wr(MODE_BASE, 8'h30);
      settle();
      check(32'({io_cfg[15:0], cap_en[3:0], cmp_en[3:0]}), 32'h0000_9830);
      rd_chk(IOL_BASE, 8'hA1);
      wr(MODE_BASE, 8'h00);
      $display("io control test done");
   endtask
   task automatic test_clock();
      int div[8] = '{1, 4, 16, 64, 256, 1024, 16, 32};
      int n;
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 8; k++) begin
            wr(CKS_BASE + 4*c, 8'(k));
            rd_chk(CKS_BASE + 4*c, 8'(k));
            settle();
            check(32'(cks[3*c +: 3]), 32'(k));
            n = 0;
            repeat (1024) begin
               @(negedge hclk);
               if (tick[c] === 1'b1) n++;
            end
            check(32'(n), 32'(1024 / div[k]));
         end
         wr(CKS_BASE + 4*c, 8'h00);
      end
      $display("clock source test done");
   endtask
   task automatic test_standby();
      wr(MODE_BASE + 12, 8'h32);
      wr(IOU_BASE + 8, 8'h5A);
      rd_chk(MODE_BASE + 12, 8'hF2);
      @(posedge hclk);
      standby_entry <= 1'b1;
      @(posedge hclk);
      standby_entry <= 1'b0;
      rd_chk(MODE_BASE + 12, 8'hC0);
      rd_chk(IOU_BASE + 8, 8'h00);
      $display("standby test done");
   endtask
   initial begin
      {hresetn, hsel, hwrite, standby_entry} = 4'h0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      htrans = 2'h0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      test_reset();
      test_fixed();
      test_modes();
      test_io();
      test_clock();
      test_standby();
      finish_test();
   end
endmodule

bind mtc_top mtc_checker mtc_checker_i (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .chan_mode(chan_mode), .buffer_pair_first(buffer_pair_first),
   .buffer_pair_second(buffer_pair_second), .gr_io_cfg(gr_io_cfg), .gr_capture_en(gr_capture_en),
   .gr_compare_en(gr_compare_en), .clock_source_select(clock_source_select), .count_tick(count_tick));
